/* File: verilog/odu_tributary_multiplexer.sv */
// Tributary multiplexer: per-tributary fifos, justification, frame build, slot identifiers
`timescale 1ns/100ps
`include "odu_mux_map.svh"

// ----------------------------------------
// Fall-through fifo
// ----------------------------------------
module odu_mux_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = `FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                     mclk,
	input  wire logic                     rst_n,
	// Fill side
	input  wire logic                     in_valid,
	output logic                          in_ready,
	input  wire logic [WIDTH-1:0]         in_data,
	// Drain side
	output logic                          out_valid,
	input  wire logic                     out_ready,
	output logic [WIDTH-1:0]              out_data,
	output logic [$clog2(DEPTH):0]        fill
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic [AW:0]      count_next;
	logic             ready_reg;
	logic             valid_reg;
	logic             push;
	logic             pop;

	assign push      = in_valid && ready_reg;
	assign pop       = out_ready && valid_reg;
	assign in_ready  = ready_reg;
	assign out_valid = valid_reg;
	assign out_data  = mem[rd_ptr_reg];
	assign fill      = count_reg;

	always_comb begin
		count_next = count_reg;
		if (push && !pop) begin
			count_next = count_reg + (AW+1)'(1);
		end else if (pop && !push) begin
			count_next = count_reg - (AW+1)'(1);
		end
	end

	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	// Explicit wrap keeps non power-of-two depths correct
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + AW'(1);
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + AW'(1);
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			count_reg <= '0;
			ready_reg <= 1'b1;
			valid_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			ready_reg <= (count_next != (AW+1)'(DEPTH));
			valid_reg <= (count_next != '0);
		end
	end
endmodule

// ----------------------------------------
// Multiplexer top
// ----------------------------------------
module odu_tributary_multiplexer #(
	parameter int         FIFO_DEPTH = `FIFO_DEPTH,
	parameter logic [7:0] FA_FIRST   = 8'ha5,
	parameter logic [7:0] FA_SECOND  = 8'h5a
) (
	// Clock and reset
	input  wire logic                                  mclk,
	input  wire logic                                  rst_n,
	// Configuration
	input  wire odu_mux_pkg::mode_e                    mode,
	input  wire logic [3:0]                            odu2_grp_en,
	input  wire logic [3:0][5:0]                       odu2_port,
	// Tributaries
	input  wire logic [`TRIB_MAX-1:0]                  trib_valid,
	output logic [`TRIB_MAX-1:0]                       trib_ready,
	input  wire odu_mux_pkg::trib_byte_s [`TRIB_MAX-1:0] trib_in,
	// Line
	input  wire logic                                  line_take,
	output logic                                       line_valid,
	output odu_mux_pkg::line_byte_s                    line_out,
	// Status
	output odu_mux_pkg::msi_byte_t [`MSI_SLOTS-1:0]    msi,
	output logic [`TRIB_MAX-1:0]                       underflow
);
	import odu_mux_pkg::*;

	localparam int FW = $clog2(FIFO_DEPTH) + 1;

	mode_e                  mode_reg;
	row_t                   row_reg;
	col_t                   col_reg;
	logic [7:0]             mfas_reg;
	logic [1:0]             just_reg;
	logic                   line_valid_reg;
	line_byte_s             line_out_reg;
	logic [`TRIB_MAX-1:0]   underflow_reg;
	msi_byte_t [`MSI_SLOTS-1:0] msi_reg;

	trib_byte_s             head [`TRIB_MAX];
	logic [FW-1:0]          fill [`TRIB_MAX];
	logic [`TRIB_MAX-1:0]   head_valid;
	logic [`TRIB_MAX-1:0]   pop_vec;
	logic [1:0]             mask;
	logic [1:0]             jtrib;
	logic [1:0]             sel_trib;
	logic                   sel_pop;
	logic [7:0]             sel_data;
	col_t                   pcol;
	logic                   frame_start;
	logic                   hold;
	logic                   advance;

	// ----------------------------------------
	// Tributary intake
	// ----------------------------------------
	genvar t;
	for (t = 0; t < `TRIB_MAX; t++) begin : g_trib
		row_t       trow_reg;
		col_t       tcol_reg;
		row_t       trow;
		col_t       tcol;
		trib_byte_s wr;
		logic       push;

		assign trow = trib_in[t].sof ? 3'h1 : trow_reg;
		assign tcol = trib_in[t].sof ? 12'h001 : tcol_reg;
		assign push = trib_valid[t] && trib_ready[t];

		// Alignment bytes pass, OTU overhead bytes are blanked
		always_comb begin
			wr = trib_in[t];
			if (trow == 3'h1 && tcol >= `OTU_OH_COL_FIRST && tcol <= `OTU_OH_COL_LAST) begin
				wr.data = 8'h00;
			end
		end

		always_ff @(posedge mclk) begin
			if (!rst_n) begin
				trow_reg <= 3'h1;
				tcol_reg <= 12'h001;
			end else if (push) begin
				if (tcol == `FRAME_COLS) begin
					tcol_reg <= 12'h001;
					trow_reg <= (trow == `FRAME_ROWS) ? 3'h1 : trow + 3'h1;
				end else begin
					tcol_reg <= tcol + 12'h001;
					trow_reg <= trow;
				end
			end
		end

		// Fifo absorbs the rate difference that justification corrects
		odu_mux_fifo #(
			.WIDTH ($bits(trib_byte_s)),
			.DEPTH (FIFO_DEPTH)
		) u_fifo (
			.mclk      (mclk),
			.rst_n     (rst_n),
			.in_valid  (trib_valid[t]),
			.in_ready  (trib_ready[t]),
			.in_data   (wr),
			.out_valid (head_valid[t]),
			.out_ready (pop_vec[t]),
			.out_data  (head[t]),
			.fill      (fill[t])
		);
	end

	// ----------------------------------------
	// Server frame position
	// ----------------------------------------
	always_comb begin
		case (mode_reg)
			MODE_MUX_4X1: mask = 2'h3;
			MODE_MUX_2X0: mask = 2'h1;
			default:      mask = 2'h0;
		endcase
	end

	assign jtrib       = mfas_reg[1:0] & mask;
	assign frame_start = (row_reg == 3'h1) && (col_reg == 12'h001);
	assign pcol        = col_reg - `PAYLOAD_COL_FIRST;
	// In frame-sync mode the frame waits until the tributary frame start heads its fifo
	assign hold        = (mode_reg == MODE_MAP_FRAMESYNC) && frame_start &&
			     !(head_valid[0] && head[0].sof);
	assign advance     = line_take && !hold;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			row_reg  <= 3'h1;
			col_reg  <= 12'h001;
			mfas_reg <= 8'h00;
			mode_reg <= MODE_MUX_4X1;
		end else if (advance) begin
			if (col_reg == `FRAME_COLS) begin
				col_reg <= 12'h001;
				if (row_reg == `FRAME_ROWS) begin
					row_reg  <= 3'h1;
					mfas_reg <= mfas_reg + 8'h01;
					// Mode only changes on a frame boundary
					mode_reg <= mode;
				end else begin
					row_reg <= row_reg + 3'h1;
				end
			end else begin
				col_reg <= col_reg + 12'h001;
			end
		end
	end

	// ----------------------------------------
	// Justification decision per frame
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			just_reg <= `JC_NONE;
		end else if (advance && frame_start) begin
			if (mode_reg == MODE_MAP_BITSYNC || mode_reg == MODE_MAP_FRAMESYNC) begin
				just_reg <= `JC_NONE;
			end else if (fill[jtrib] < `FILL_LOW) begin
				just_reg <= `JC_POS;
			end else if (fill[jtrib] > `FILL_HIGH) begin
				just_reg <= `JC_NEG;
			end else begin
				just_reg <= `JC_NONE;
			end
		end
	end

	// ----------------------------------------
	// Byte selection
	// ----------------------------------------
	always_comb begin
		sel_trib = 2'h0;
		sel_pop  = 1'b0;
		sel_data = 8'h00;
		if (row_reg == 3'h1 && col_reg <= `MFAS_COL) begin
			if (col_reg <= `FA_SPLIT_COL) begin
				sel_data = FA_FIRST;
			end else if (col_reg < `MFAS_COL) begin
				sel_data = FA_SECOND;
			end else begin
				sel_data = mfas_reg;
			end
		end else if (col_reg < `OPU_OH_COL) begin
			sel_data = 8'h00;
		end else if (col_reg == `OPU_OH_COL) begin
			if (row_reg <= `JC_ROW_LAST) begin
				sel_data = {6'h00, just_reg};
			end else if (just_reg == `JC_NEG) begin
				sel_trib = jtrib;
				sel_pop  = 1'b1;
			end
		end else begin
			sel_trib = pcol[1:0] & mask;
			// First byte of the owning tributary in row 4 is the stuff slot
			if (!(row_reg == `NJO_ROW && just_reg == `JC_POS &&
			      sel_trib == jtrib && pcol <= {10'h000, mask})) begin
				sel_pop = 1'b1;
			end
		end
		if (sel_pop && head_valid[sel_trib]) begin
			sel_data = head[sel_trib].data;
		end
	end

	// Frame-sync slip: bytes ahead of the tributary frame start are dropped, else the hold never ends
	assign pop_vec = (advance && sel_pop) ? (4'h1 << sel_trib) :
			 {3'h0, hold && head_valid[0]};

	// ----------------------------------------
	// Line output
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			line_valid_reg <= 1'b0;
			line_out_reg   <= '0;
			underflow_reg  <= '0;
		end else begin
			line_valid_reg <= advance;
			// An empty fifo gives a zero byte rather than stalling the line
			underflow_reg  <= pop_vec & ~head_valid;
			if (advance) begin
				line_out_reg <= '{sof: frame_start, row: row_reg, col: col_reg,
						  data: sel_data};
			end
		end
	end

	// ----------------------------------------
	// Slot identifier bytes
	// ----------------------------------------
	genvar s;
	for (s = 0; s < `MSI_SLOTS; s++) begin : g_msi
		always_ff @(posedge mclk) begin
			if (!rst_n) begin
				msi_reg[s] <= {`MSI_TYPE_ODU1, 6'(s)};
			end else if (odu2_grp_en[s % 4]) begin
				msi_reg[s] <= {`MSI_TYPE_ODU2, odu2_port[s % 4]};
			end else begin
				msi_reg[s] <= {`MSI_TYPE_ODU1, 6'(s)};
			end
		end
	end

	assign line_valid = line_valid_reg;
	assign line_out   = line_out_reg;
	assign underflow  = underflow_reg;
	assign msi        = msi_reg;
endmodule

/* File: verilog/odu_mux_map.svh */
// Frame geometry, overhead positions, justification codes and fifo limits
`ifndef ODU_MUX_MAP_SVH
`define ODU_MUX_MAP_SVH

// ----------------------------------------
// Frame geometry
// ----------------------------------------
`define FRAME_ROWS        3'h4
`define FRAME_COLS        12'hef0
`define FA_SPLIT_COL      12'h003
`define MFAS_COL          12'h007
`define OTU_OH_COL_FIRST  12'h008
`define OTU_OH_COL_LAST   12'h00e
`define OPU_OH_COL        12'h010
`define PAYLOAD_COL_FIRST 12'h011
`define JC_ROW_LAST       3'h3
`define NJO_ROW           3'h4

// ----------------------------------------
// Justification control codes
// ----------------------------------------
`define JC_NONE           2'h0
`define JC_NEG            2'h1
`define JC_POS            2'h3

// ----------------------------------------
// Fifo fill limits and sizes
// ----------------------------------------
`define FILL_LOW          4'h2
`define FILL_HIGH         4'h6
`define FIFO_DEPTH        8
`define TRIB_MAX          4
`define MSI_SLOTS         16
`define MSI_TYPE_ODU1     2'h0
`define MSI_TYPE_ODU2     2'h1

`endif

/* File: verilog/odu_mux_pkg.sv */
// Types shared by the tributary multiplexer
package odu_mux_pkg;
	typedef logic [11:0] col_t;
	typedef logic [2:0]  row_t;
	typedef logic [7:0]  msi_byte_t;

	typedef enum logic [4:0] {
		MODE_MUX_4X1       = 5'h01,
		MODE_MUX_2X0       = 5'h02,
		MODE_MAP_ASYNC     = 5'h04,
		MODE_MAP_BITSYNC   = 5'h08,
		MODE_MAP_FRAMESYNC = 5'h10
	} mode_e;

	typedef struct packed {
		logic       sof;
		logic [7:0] data;
	} trib_byte_s;

	typedef struct packed {
		logic       sof;
		row_t       row;
		col_t       col;
		logic [7:0] data;
	} line_byte_s;
endpackage

/* File: test/odu_tributary_multiplexer_checker.sv */
// Assertions on line framing and slot identifier outputs
`timescale 1ns/100ps
`include "odu_mux_map.svh"
module odu_tributary_multiplexer_checker #(
	parameter logic [7:0] FA_FIRST  = 8'ha5,
	parameter logic [7:0] FA_SECOND = 8'h5a
) (
	// Clock and reset
	input wire logic                                     mclk,
	input wire logic                                     rst_n,
	// Identifier configuration
	input wire logic [3:0]                               odu2_grp_en,
	input wire logic [3:0][5:0]                          odu2_port,
	// Line and status
	input wire logic                                     line_take,
	input wire logic                                     line_valid,
	input wire odu_mux_pkg::line_byte_s                  line_out,
	input wire odu_mux_pkg::msi_byte_t [`MSI_SLOTS-1:0] msi
);
	import odu_mux_pkg::*;
	// ------
	// Helper state
	// ------
	msi_byte_t [15:0] msi_exp_reg;
	row_t             last_row_reg;
	col_t             last_col_reg;
	logic             seen_reg;
	wire row_t        r = line_out.row;
	wire col_t        c = line_out.col;
	wire logic [7:0]  d = line_out.data;

	always_ff @(posedge mclk) begin
		for (int s = 0; s < 16; s++) begin
			msi_exp_reg[s] <= odu2_grp_en[s % 4] ? {2'h1, odu2_port[s % 4]} : {2'h0, 6'(s)};
		end
	end
	// Last position is only meaningful once a byte has gone out
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			seen_reg <= 1'b0;
		end else if (line_valid) begin
			seen_reg <= 1'b1;
		end
	end
	always_ff @(posedge mclk) begin
		if (line_valid) begin
			last_row_reg <= r;
			last_col_reg <= c;
		end
	end
	// ------
	// Properties
	// ------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	sequence s_in_row;
		line_valid && seen_reg && last_col_reg != `FRAME_COLS;
	endsequence
	sequence s_row_end;
		line_valid && seen_reg && last_col_reg == `FRAME_COLS;
	endsequence
	a_col_step: assert property (s_in_row |-> c == last_col_reg + 12'h001 && r == last_row_reg)
		else $error("column did not advance by one");
	a_row_wrap: assert property (s_row_end |-> c == 12'h001
		&& r == ((last_row_reg == `FRAME_ROWS) ? 3'h1 : last_row_reg + 3'h1))
		else $error("row did not wrap after last column");
	a_take_answer: assert property (line_valid |-> $past(line_take))
		else $error("byte produced without a take");
	a_fa_first: assert property (line_valid && r == 3'h1 && c inside {[12'h001:12'h003]}
		|-> d == FA_FIRST)
		else $error("first alignment byte wrong");
	a_fa_second: assert property (line_valid && r == 3'h1 && c inside {[12'h004:12'h006]}
		|-> d == FA_SECOND)
		else $error("second alignment byte wrong");
	a_oh_zero: assert property (line_valid && c inside {[12'h008:12'h00f]} |-> d == 8'h00)
		else $error("overhead byte not zero");
	a_jc_code: assert property (line_valid && c == 12'h010 && r != 3'h4
		|-> d inside {8'h00, 8'h01, 8'h03})
		else $error("justification control byte illegal");
	a_sof_mark: assert property (line_valid |-> line_out.sof == (r == 3'h1 && c == 12'h001))
		else $error("frame start mark misplaced");
	a_msi_code: assert property (msi == msi_exp_reg)
		else $error("slot identifier bytes wrong");
endmodule

bind odu_tributary_multiplexer odu_tributary_multiplexer_checker #(
	.FA_FIRST (FA_FIRST),
	.FA_SECOND(FA_SECOND)
) i_chk (
	.mclk       (mclk),
	.rst_n      (rst_n),
	.odu2_grp_en(odu2_grp_en),
	.odu2_port  (odu2_port),
	.line_take  (line_take),
	.line_valid (line_valid),
	.line_out   (line_out),
	.msi        (msi)
);

/* File: test/odu_line_sink.sv */
// Line-side partner: takes bytes every cycle or with random stalls
`timescale 1ns/100ps
module odu_line_sink (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rst_n,
	// Pace control
	input  wire logic slow,
	// Line request
	output logic      line_take
);
	int seed = 57;
	initial line_take = 1'b0;
	// Stalls a quarter of cycles when slow, so position hold is exercised
	always @(posedge mclk) begin
		line_take <= rst_n && (!slow || ($random(seed) & 3) != 0);
	end
endmodule

/* File: test/odu_tributary_multiplexer_tb.sv */
// Self-checking bench: random tributary feed, line scoreboard, identifier sweep
`timescale 1ns/100ps
module odu_tributary_multiplexer_tb;
	import odu_mux_pkg::*;
	logic             mclk, rst_n, line_take, line_valid, slow;
	logic [3:0]       grp, trib_valid, trib_ready, underflow;
	logic [3:0][5:0]  port;
	trib_byte_s [3:0] trib_in;
	line_byte_s       line_out;
	msi_byte_t [15:0] msi;
	mode_e            mode, cur;
	int               err_count, n_compared, fr, mask, jc, mf, o, r, c, k[4];
	int               seed = 57;
	int               q[4][$];
	mode_e            seq[7] = '{MODE_MUX_4X1, MODE_MUX_2X0, MODE_MAP_ASYNC,
	                             MODE_MAP_BITSYNC, MODE_MAP_FRAMESYNC,
	                             MODE_MUX_4X1, MODE_MUX_4X1};

	odu_tributary_multiplexer i_dut (.mclk(mclk), .rst_n(rst_n), .mode(mode),
		.odu2_grp_en(grp), .odu2_port(port), .trib_valid(trib_valid),
		.trib_ready(trib_ready), .trib_in(trib_in), .line_take(line_take),
		.line_valid(line_valid), .line_out(line_out), .msi(msi), .underflow(underflow));
	odu_line_sink i_sink (.mclk(mclk), .rst_n(rst_n), .slow(slow), .line_take(line_take));

	task automatic cmp8(string what, logic [7:0] exp, logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic report_and_stop;
		$display("mismatches %0d compared %0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// OTU-overhead slots of each tributary frame come out zeroed
	function automatic logic [7:0] trib_exp(int t, int n);
		return ((n % 15296) inside {[7:13]}) ? 8'h00 : {t[1:0], 1'b1, n[4:0]};
	endfunction
	function automatic logic [7:0] msi_exp(int s);
		return grp[s % 4] ? {2'h1, port[s % 4]} : {2'h0, 6'(s)};
	endfunction

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// ------
	// Tributary feed: random gaps, data held while refused
	// ------
	always @(posedge mclk) begin
		for (int t = 0; t < 4; t++) begin
			if (rst_n && trib_valid[t] && trib_ready[t]) begin
				q[t].push_back(k[t]);
				k[t]++;
			end
			if (!trib_valid[t] || trib_ready[t]) begin
				// Full rate on the aligned tributary keeps the frame-start search short
				trib_valid[t] <= rst_n && ((mode == MODE_MAP_FRAMESYNC && t == 0) ||
				                           ($random(seed) & 1));
				trib_in[t] <= '{k[t] % 15296 == 0, {t[1:0], 1'b1, k[t][4:0]}};
			end
		end
	end
	// ------
	// Line scoreboard
	// ------
	always @(posedge mclk) begin
		if (rst_n && line_valid) begin
			r = line_out.row;
			c = line_out.col;
			if (r == 1 && c == 1) begin
				cur = seq[fr];
				fr++;
				mode <= seq[fr];
				// One stalled frame keeps the run short
				slow <= (fr == 3);
				mask = cur == MODE_MUX_4X1 ? 3 : cur == MODE_MUX_2X0 ? 1 : 0;
				// Bytes dropped by the frame-start search never reach the line
				if (cur == MODE_MAP_FRAMESYNC)
					while (q[0].size() && q[0][0] % 15296 != 0)
						void'(q[0].pop_front());
			end
			if (r == 1 && c == 7)
				mf = line_out.data[1:0] & mask;
			if (r == 1 && c == 16)
				jc = line_out.data[1:0];
			if (r == 1 && c == 16 && cur inside {MODE_MAP_BITSYNC, MODE_MAP_FRAMESYNC})
				cmp8("jc", 8'h00, line_out.data);
			if (r == 1 && c == 17 && cur == MODE_MAP_FRAMESYNC)
				cmp8("frame start", trib_exp(0, 0), line_out.data);
			o = c >= 17 ? (c - 17) & mask : -1;
			if (c == 16 && r == 4 && jc == 1)
				o = mf;
			if (c >= 17 && r == 4 && jc == 3 && c - 17 <= mask && o == mf)
				o = -2;
			if (o == -2 || (c == 16 && r == 4 && jc != 1))
				cmp8("stuff", 8'h00, line_out.data);
			else if (o >= 0 && underflow[o])
				cmp8("underflow", 8'h00, line_out.data);
			else if (o >= 0)
				cmp8("payload", q[o].size() ? trib_exp(o, q[o].pop_front()) : 8'hxx,
				     line_out.data);
		end
	end

	initial begin
		rst_n = 1'b0;
		mode = MODE_MUX_4X1;
		grp = 4'h0;
		port = '0;
		slow = 1'b0;
		trib_valid = 4'h0;
		trib_in = '0;
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		#1;
		for (int s = 0; s < 16; s++)
			cmp8("msi", {2'h0, 6'(s)}, msi[s]);
		for (int i = 0; i < 12; i++) begin
			@(posedge mclk);
			grp <= i == 0 ? 4'hf : i == 1 ? 4'h9 : 4'($random(seed));
			port <= 24'($random(seed));
			repeat (2) @(posedge mclk);
			#1;
			for (int s = 0; s < 16; s++)
				cmp8("msi", msi_exp(s), msi[s]);
		end
		for (int n = 0; n < 99000 && fr < 6; n++)
			@(posedge mclk);
		if (fr < 6)
			err_count++;
		report_and_stop();
	end
endmodule
